// ---- src/mac_dma_interrupt_gate.sv ----
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Function
// - too-short frame sets status bit 2
// - mii receive error sets status bit 1
// - crc failure sets status bit 0
// - one enable bit per status bit
// - enable 1 permits, 0 blocks source
// - reset clears all enable bits
// - reserved enable bits read zero, unwritable
// - bit 24 gates frame counter overflow
// - bit 22 gates whole mac status group
// - bits 21..19 gate transmit dma events
// - bits 18..16 gate receive dma events
// - bits 12..8 gate transmit error events
// - frame under 64 bytes is too short
module mac_dma_interrupt_gate
	import irq_gate_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// register port
	input  wire reg_req_t    BUS_REQ,
	output logic [31:0]      RDATA,
	// event sources on the system clock
	input  wire logic [31:0] SRC_EVENT,
	input  wire logic        MAC_STATUS_IRQ,
	input  wire rx_report_t  RX_REPORT,
	// receive error pin from the phy
	input  wire logic        MII_RX_ERR,
	// combined interrupt request
	output logic             IRQ
);

	////////////////////////////////////////////////////////////////////
	// declarations
	logic [31:0] status_interrupt_enable;
	logic [31:0] next_enable;
	logic [31:0] mac_dma_status_reg;
	logic [31:0] sticky;
	logic [31:0] next_sticky;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [31:0] pending;
	logic [31:0] next_rdata;
	logic        phy_err_sync;
	logic        phy_err_prev;
	logic        next_phy_err_prev;
	logic        phy_err_evt;
	logic        short_evt;
	logic        crc_evt;
	logic        enable_hit;
	logic        status_hit;

	////////////////////////////////////////////////////////////////////
	// receive-side event sources

	// bring the phy error pin into the clock domain
	pin_sync pin_sync_i (
		.CLK      (CLK),
		.NRST     (NRST),
		.async_in (MII_RX_ERR),
		.sync_out (phy_err_sync)
	);

	// length and crc checks on each finished frame
	frame_checker frame_checker_i (
		.CLK       (CLK),
		.NRST      (NRST),
		.report    (RX_REPORT),
		.short_evt (short_evt),
		.crc_evt   (crc_evt)
	);

	// previous synced level for edge detection
	always_comb begin
		next_phy_err_prev = phy_err_sync;
	end

	// edge detector register
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			phy_err_prev <= 1'b0;
		end else begin
			phy_err_prev <= next_phy_err_prev;
		end
	end

	// one event per error notification
	assign phy_err_evt = phy_err_sync && !phy_err_prev;

	////////////////////////////////////////////////////////////////////
	// address decode
	assign enable_hit = (BUS_REQ.addr == ENABLE_OFS);
	assign status_hit = (BUS_REQ.addr == STATUS_OFS);

	////////////////////////////////////////////////////////////////////
	// interrupt enable register

	// writes store only implemented bits
	always_comb begin
		next_enable = status_interrupt_enable;
		if (BUS_REQ.wr && enable_hit) begin
			next_enable = BUS_REQ.wdata & IMPL_MASK;
		end
	end

	// enable register, cleared by reset
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			status_interrupt_enable <= ENABLE_RST;
		end else begin
			status_interrupt_enable <= next_enable;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags

	// set sources: locally made receive events, the rest from dma/mac
	always_comb begin
		set_vec                   = SRC_EVENT & STICKY_MASK;
		set_vec[CRC_ERR_BIT]      = crc_evt;
		set_vec[PHY_ERR_BIT]      = phy_err_evt;
		set_vec[SHORT_FRAME_BIT]  = short_evt;
	end

	// writing one clears a flag
	assign clr_vec = (BUS_REQ.wr && status_hit) ? BUS_REQ.wdata : 32'h0000_0000;

	// sticky flag per bit; a set in the clearing cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (STICKY_MASK[gi]) begin : g_live
				assign next_sticky[gi] = set_vec[gi] || (sticky[gi] && !clr_vec[gi]);
			end else begin : g_none
				assign next_sticky[gi] = 1'b0;
			end
		end
	endgenerate

	// flag register
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			sticky <= STATUS_RST;
		end else begin
			sticky <= next_sticky;
		end
	end

	// visible status: sticky flags plus the live mac group level
	always_comb begin
		mac_dma_status_reg                = sticky;
		mac_dma_status_reg[MAC_GROUP_BIT] = MAC_STATUS_IRQ;
	end

	////////////////////////////////////////////////////////////////////
	// interrupt request

	// each source is gated by the enable at its own position
	assign pending = mac_dma_status_reg & status_interrupt_enable;
	assign IRQ     = |pending;

	////////////////////////////////////////////////////////////////////
	// read data, valid the cycle after the read strobe

	// unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (BUS_REQ.rd && enable_hit) begin
			next_rdata = status_interrupt_enable;
		end else if (BUS_REQ.rd && status_hit) begin
			next_rdata = mac_dma_status_reg;
		end
	end

	// read data register
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge CLK);
	endclocking

	default disable iff (!NRST);

	// enables read as zero in the cycle after reset
	a_enable_reset_clear: assert property (
		@(posedge CLK) disable iff (1'b0)
		!NRST |=> (status_interrupt_enable == 32'h0000_0000))
		else $error("enable register not cleared by reset");

	// reserved enable bits never hold a one
	a_reserved_stay_zero: assert property (
		(status_interrupt_enable & ~IMPL_MASK) == 32'h0000_0000)
		else $error("reserved enable bit set");

	// an enable write lands masked in the next cycle
	a_enable_write_lands: assert property (
		(BUS_REQ.wr && enable_hit)
		|=> (status_interrupt_enable == ($past(BUS_REQ.wdata) & IMPL_MASK)))
		else $error("enable write not stored");

	// a short frame sets bit 2 two cycles later
	a_short_frame_flag: assert property (
		(RX_REPORT.done && RX_REPORT.len < MIN_FRAME_LEN)
		|-> ##2 mac_dma_status_reg[SHORT_FRAME_BIT])
		else $error("short frame did not set flag");

	// a legal length alone never sets bit 2
	a_long_not_short: assert property (
		(!RX_REPORT.done || RX_REPORT.len >= MIN_FRAME_LEN)
		##1 (!sticky[SHORT_FRAME_BIT])
		|=> !sticky[SHORT_FRAME_BIT])
		else $error("short flag set without short frame");

	// a crc failure sets bit 0 two cycles later
	a_crc_error_flag: assert property (
		(RX_REPORT.done && RX_REPORT.crc_bad)
		|-> ##2 mac_dma_status_reg[CRC_ERR_BIT])
		else $error("crc failure did not set flag");

	// a rising phy error pin sets bit 1 within four cycles
	a_phy_error_flag: assert property (
		$rose(MII_RX_ERR) ##1 MII_RX_ERR ##1 MII_RX_ERR
		|-> ##[1:2] mac_dma_status_reg[PHY_ERR_BIT])
		else $error("phy error did not set flag");

	// a set beats a clear in the same cycle
	a_set_beats_clear: assert property (
		(short_evt && BUS_REQ.wr && status_hit && BUS_REQ.wdata[SHORT_FRAME_BIT])
		|=> sticky[SHORT_FRAME_BIT])
		else $error("clear won over set");

	// a write-one clear drops an idle flag
	a_clear_drops_flag: assert property (
		(BUS_REQ.wr && status_hit && BUS_REQ.wdata[CRC_ERR_BIT] && !crc_evt)
		|=> !sticky[CRC_ERR_BIT])
		else $error("flag not cleared by write");

	// request follows any enabled flag and nothing else
	a_request_matches: assert property (
		IRQ == ((|(sticky & status_interrupt_enable))
			|| (MAC_STATUS_IRQ && status_interrupt_enable[MAC_GROUP_BIT])))
		else $error("request does not match enabled flags");

	// a disabled flag alone never raises the request
	a_disabled_blocked: assert property (
		(mac_dma_status_reg == 32'h0000_0001 << SHORT_FRAME_BIT)
		&& !status_interrupt_enable[SHORT_FRAME_BIT] |-> !IRQ)
		else $error("disabled source raised request");

	// the mac group follows its enable bit
	a_mac_group_gate: assert property (
		(mac_dma_status_reg == 32'h0040_0000)
		|-> (IRQ == status_interrupt_enable[MAC_GROUP_BIT]))
		else $error("mac group gate wrong");

	// a status read returns the value from the strobe cycle
	a_status_readback: assert property (
		(BUS_REQ.rd && status_hit) |=> (RDATA == $past(mac_dma_status_reg)))
		else $error("status read data wrong");

	// an enable read returns the stored value from the strobe cycle
	a_enable_readback: assert property (
		(BUS_REQ.rd && enable_hit) |=> (RDATA == $past(status_interrupt_enable)))
		else $error("enable read data wrong");

	// reads of unmapped offsets return zero
	a_unmapped_read_zero: assert property (
		(BUS_REQ.rd && !enable_hit && !status_hit) |=> (RDATA == 32'h0000_0000))
		else $error("unmapped read not zero");

	// reserved status positions never show a one
	a_reserved_status_zero: assert property (
		(mac_dma_status_reg & ~IMPL_MASK) == 32'h0000_0000)
		else $error("reserved status bit set");

	// no request in the cycle after a reset edge
	a_reset_irq_low: assert property (
		@(posedge CLK) disable iff (1'b0)
		!NRST |=> !IRQ)
		else $error("request high after reset");

	// all sticky flags are gone after a reset edge
	a_reset_flags_clear: assert property (
		@(posedge CLK) disable iff (1'b0)
		!NRST |=> (sticky == 32'h0000_0000))
		else $error("flags not cleared by reset");

	// a receive overflow event pulse sets its own flag one cycle later
	a_event_sets_flag: assert property (
		SRC_EVENT[RX_OVERFLOW_BIT] |=> sticky[RX_OVERFLOW_BIT])
		else $error("event pulse did not set flag");

	// counter overflow alone follows its enable bit
	a_count_ov_gate: assert property (
		(mac_dma_status_reg == (32'h0000_0001 << FRAME_CNT_OV_BIT))
		|-> (IRQ == status_interrupt_enable[FRAME_CNT_OV_BIT]))
		else $error("counter overflow gate wrong");

	// transmit complete alone follows its enable bit
	a_tx_done_gate: assert property (
		(mac_dma_status_reg == (32'h0000_0001 << TX_DONE_BIT))
		|-> (IRQ == status_interrupt_enable[TX_DONE_BIT]))
		else $error("transmit complete gate wrong");

	// frame received alone follows its enable bit
	a_rx_frame_gate: assert property (
		(mac_dma_status_reg == (32'h0000_0001 << FRAME_RX_BIT))
		|-> (IRQ == status_interrupt_enable[FRAME_RX_BIT]))
		else $error("frame received gate wrong");

	// illegal transmit frame alone follows its enable bit
	a_tx_error_gate: assert property (
		(mac_dma_status_reg == (32'h0000_0001 << ILLEGAL_TX_BIT))
		|-> (IRQ == status_interrupt_enable[ILLEGAL_TX_BIT]))
		else $error("transmit error gate wrong");

	// multicast frame alone follows its enable bit
	a_rx_status_gate: assert property (
		(mac_dma_status_reg == (32'h0000_0001 << MULTICAST_BIT))
		|-> (IRQ == status_interrupt_enable[MULTICAST_BIT]))
		else $error("receive status gate wrong");

	// main scenarios
	c_irq_raised: cover property (!IRQ ##1 IRQ);
	c_short_frame: cover property (short_evt ##1 sticky[SHORT_FRAME_BIT]);
	c_set_and_clear: cover property (
		short_evt && BUS_REQ.wr && status_hit && BUS_REQ.wdata[SHORT_FRAME_BIT]);
	c_mac_group_irq: cover property (MAC_STATUS_IRQ && status_interrupt_enable[MAC_GROUP_BIT]);
	c_phy_error: cover property (phy_err_evt ##1 sticky[PHY_ERR_BIT]);

endmodule // mac_dma_interrupt_gate

// ---- src/irq_gate_pkg.sv ----
package irq_gate_pkg;

	// register port geometry
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned LEN_W       = 11;

	// register offsets (byte addresses)
	localparam logic [7:0]  ENABLE_OFS  = 8'h00;
	localparam logic [7:0]  STATUS_OFS  = 8'h04;

	// status / enable bit positions
	localparam int unsigned CRC_ERR_BIT      = 0;
	localparam int unsigned PHY_ERR_BIT      = 1;
	localparam int unsigned SHORT_FRAME_BIT  = 2;
	localparam int unsigned LONG_FRAME_BIT   = 3;
	localparam int unsigned RESIDUAL_BIT     = 4;
	localparam int unsigned DISCARD_REQ_BIT  = 5;
	localparam int unsigned MULTICAST_BIT    = 7;
	localparam int unsigned RETRY_OVER_BIT   = 8;
	localparam int unsigned COLLISION_BIT    = 9;
	localparam int unsigned CARRIER_LOST_BIT = 10;
	localparam int unsigned CARRIER_MISS_BIT = 11;
	localparam int unsigned ILLEGAL_TX_BIT   = 12;
	localparam int unsigned RX_OVERFLOW_BIT  = 16;
	localparam int unsigned RX_DESC_EX_BIT   = 17;
	localparam int unsigned FRAME_RX_BIT     = 18;
	localparam int unsigned TX_UNDERFLOW_BIT = 19;
	localparam int unsigned TX_DESC_EX_BIT   = 20;
	localparam int unsigned TX_DONE_BIT      = 21;
	localparam int unsigned MAC_GROUP_BIT    = 22;
	localparam int unsigned FRAME_CNT_OV_BIT = 24;

	// implemented bits; everything else is reserved and reads zero
	localparam logic [31:0] IMPL_MASK   = 32'h017f_1fbf;
	// bits that latch as sticky flags (the mac group bit is a live level)
	localparam logic [31:0] STICKY_MASK = 32'h013f_1fbf;

	// reset values
	localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
	localparam logic [31:0] STATUS_RST  = 32'h0000_0000;

	// shortest legal received frame, in bytes
	localparam logic [10:0] MIN_FRAME_LEN = 11'h040;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// end-of-frame report from the receive path
	typedef struct packed {
		logic        done;
		logic [10:0] len;
		logic        crc_bad;
	} rx_report_t;

endpackage

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
	// clock and reset
	input  wire logic CLK,
	input  wire logic NRST,
	// asynchronous level in, synchronised level out
	input  wire logic async_in,
	output logic      sync_out
);

	logic stage1;
	logic next_stage1;
	logic next_sync_out;

	// next values: stage1 feeds only the second flop
	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	// two-flop synchroniser
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end

endmodule // pin_sync

// ---- src/frame_checker.sv ----
`timescale 1ns/1ps
module frame_checker
	import irq_gate_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       NRST,
	// end-of-frame report
	input  wire rx_report_t report,
	// one-cycle error events
	output logic            short_evt,
	output logic            crc_evt
);

	logic next_short_evt;
	logic next_crc_evt;

	// classify each finished frame
	always_comb begin
		next_short_evt = report.done && (report.len < MIN_FRAME_LEN);
		next_crc_evt   = report.done && report.crc_bad;
	end

	// register the events
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			short_evt <= 1'b0;
			crc_evt   <= 1'b0;
		end else begin
			short_evt <= next_short_evt;
			crc_evt   <= next_crc_evt;
		end
	end

endmodule // frame_checker

// ---- dv/mac_dma_interrupt_gate_bench.sv ----
`timescale 1ns/1ps
module mac_dma_interrupt_gate_bench;
	import irq_gate_pkg::*;

	// enable bits that are stored; all others are reserved
	localparam logic [31:0] STORED   = 32'h017f_1fbf;
	// sticky sources fed through the event port
	localparam logic [31:0] SRC_BITS = 32'h013f_1fb8;

	// design ports
	logic        CLK;
	logic        NRST;
	reg_req_t    BUS_REQ;
	logic [31:0] RDATA;
	logic [31:0] SRC_EVENT;
	logic        MAC_STATUS_IRQ;
	rx_report_t  RX_REPORT;
	logic        MII_RX_ERR;
	logic        IRQ;

	// bench state
	int          n_fail;
	int          checked;
	logic [31:0] rd_val;

	mac_dma_interrupt_gate mac_dma_interrupt_gate_i (
		.CLK            (CLK),
		.NRST           (NRST),
		.BUS_REQ        (BUS_REQ),
		.RDATA          (RDATA),
		.SRC_EVENT      (SRC_EVENT),
		.MAC_STATUS_IRQ (MAC_STATUS_IRQ),
		.RX_REPORT      (RX_REPORT),
		.MII_RX_ERR     (MII_RX_ERR),
		.IRQ            (IRQ)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock and time-zero values
	initial begin
		CLK = 1'b0;
		NRST = 1'b0;
		BUS_REQ = '0;
		SRC_EVENT = '0;
		MAC_STATUS_IRQ = 1'b0;
		RX_REPORT = '0;
		MII_RX_ERR = 1'b0;
		n_fail = 0;
		checked = 0;
	end
	always #50 CLK = ~CLK;

	////////////////////////////////////////////////////////////////////////////
	// compare, bus and stimulus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_irq(input logic exp);
		checked++;
		if (IRQ !== exp) begin
			n_fail++;
			$display("ERROR t=%0t irq got=%h exp=%h", $time, IRQ, exp);
		end
	endtask

	// one-cycle write; effect visible just after the closing edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLK);
		BUS_REQ.wr <= 1'b0;
		#1;
	endtask

	// one-cycle read; data sampled in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CLK);
		BUS_REQ <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge CLK);
		BUS_REQ.rd <= 1'b0;
		#1;
		d = RDATA;
	endtask

	task automatic pulse(input logic [31:0] ev);
		@(posedge CLK);
		SRC_EVENT <= ev;
		@(posedge CLK);
		SRC_EVENT <= '0;
		#1;
	endtask

	task automatic frame(input logic [10:0] len, input logic bad);
		@(posedge CLK);
		RX_REPORT <= '{done: 1'b1, len: len, crc_bad: bad};
		@(posedge CLK);
		RX_REPORT <= '0;
		@(posedge CLK);
	endtask

	task automatic do_reset();
		@(posedge CLK);
		NRST <= 1'b0;
		repeat (6) @(posedge CLK);
		NRST <= 1'b1;
	endtask

	task automatic end_of_test();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the expected run
	initial begin
		#3000000;
		n_fail++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		repeat (6) @(posedge CLK);
		NRST <= 1'b1;
		rd(ENABLE_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		#100;
		chk(RDATA, 32'h0000_0000);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		// probe: ones in reserved positions must be dropped
		wr(ENABLE_OFS, 32'hffff_ffff);
		rd(ENABLE_OFS, rd_val);
		chk(rd_val, STORED);
		// unmapped address: write dropped, read zero
		wr(8'h0c, 32'h0000_0000);
		rd(8'h0c, rd_val);
		chk(rd_val, 32'h0000_0000);
		rd(ENABLE_OFS, rd_val);
		chk(rd_val, STORED);
		wr(ENABLE_OFS, 32'h0000_0000);
		// every event-port source: blocked, then permitted, then cleared
		for (int b = 3; b < 25; b++) begin
			if (SRC_BITS[b]) begin
				pulse(32'h0000_0001 << b);
				chk_irq(1'b0);
				rd(STATUS_OFS, rd_val);
				chk(rd_val, 32'h0000_0001 << b);
				wr(ENABLE_OFS, 32'h0000_0001 << b);
				chk_irq(1'b1);
				wr(STATUS_OFS, 32'h0000_0001 << b);
				chk_irq(1'b0);
				wr(ENABLE_OFS, 32'h0000_0000);
			end
		end
		// reserved and non-event positions on the event port are ignored
		pulse(32'hfec0_e047);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		// mac status group follows its level through bit 22
		@(posedge CLK);
		MAC_STATUS_IRQ <= 1'b1;
		wr(ENABLE_OFS, 32'h0000_0000);
		chk_irq(1'b0);
		wr(ENABLE_OFS, 32'h0040_0000);
		chk_irq(1'b1);
		@(posedge CLK);
		MAC_STATUS_IRQ <= 1'b0;
		@(posedge CLK);
		#1;
		chk_irq(1'b0);
		// receive report: length boundary and crc
		wr(ENABLE_OFS, 32'h0000_0005);
		frame(11'h03f, 1'b0);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0004);
		chk_irq(1'b1);
		wr(STATUS_OFS, 32'h0000_0004);
		frame(11'h040, 1'b0);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		chk_irq(1'b0);
		frame(11'h100, 1'b1);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0001);
		chk_irq(1'b1);
		wr(STATUS_OFS, 32'h0000_0001);
		// short frame event meets a clear of bit 2 in one cycle: set wins
		@(posedge CLK);
		RX_REPORT <= '{done: 1'b1, len: 11'h010, crc_bad: 1'b0};
		@(posedge CLK);
		RX_REPORT <= '0;
		BUS_REQ <= '{addr: STATUS_OFS, wdata: 32'h0000_0004, wr: 1'b1, rd: 1'b0};
		@(posedge CLK);
		BUS_REQ.wr <= 1'b0;
		#1;
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0004);
		wr(STATUS_OFS, 32'h0000_0004);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		// phy error pin held high gives one event
		wr(ENABLE_OFS, 32'h0000_0002);
		@(posedge CLK);
		MII_RX_ERR <= 1'b1;
		repeat (6) @(posedge CLK);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0002);
		chk_irq(1'b1);
		wr(STATUS_OFS, 32'h0000_0002);
		repeat (4) @(posedge CLK);
		rd(STATUS_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		@(posedge CLK);
		MII_RX_ERR <= 1'b0;
		// reset in mid-run clears the enables again
		wr(ENABLE_OFS, 32'h0000_1f00);
		do_reset();
		rd(ENABLE_OFS, rd_val);
		chk(rd_val, 32'h0000_0000);
		chk_irq(1'b0);
		end_of_test();
	end

endmodule // mac_dma_interrupt_gate_bench
